// *** hdl/pwmdu_consts.vh ***
/*
 constants of the pwm duty and period update block: register offsets,
 field positions, reset values and duty scaling.
 assumes a byte-addressed apb bus with one 32-bit word per register.
*/
`ifndef PWMDU_CONSTS_VH
`define PWMDU_CONSTS_VH

// channel count and address layout
`define PWMDU_NCH 4
`define PWMDU_CH_BITS 2
`define PWMDU_ADDR_W 8
`define PWMDU_CH_SPAN 8'h10
`define PWMDU_CH_LIMIT 8'h40

// per-channel register offsets within a channel's span
`define PWMDU_OFS_CFG 4'h0
`define PWMDU_OFS_DUTY 4'h4
`define PWMDU_OFS_PERIOD 4'h8
`define PWMDU_OFS_PDREQ 4'hC

// global register
`define PWMDU_OFS_OUTS 8'h40

// configuration field positions
`define PWMDU_CFG_POL 0
`define PWMDU_CFG_IDLE 1
`define PWMDU_CFG_CLS_LO 2
`define PWMDU_CFG_CLS_HI 3
`define PWMDU_CFG_DEFD 4
`define PWMDU_CFG_DEFP 5
`define PWMDU_CFG_EN 6
`define PWMDU_CFG_W 7

// channel classes
`define PWMDU_CLS_FIXED 2'h0
`define PWMDU_CLS_SHIFT 2'h1
`define PWMDU_CLS_VAR 2'h2

// reset values
`define PWMDU_CFG_RST 7'h49
`define PWMDU_PERIOD_RST 16'h03E8
`define PWMDU_DUTY_RST 16'h4000

// duty scaling: full scale and shift that divides by it
`define PWMDU_DUTY_FULL 16'h8000
`define PWMDU_DUTY_SHIFT 15

`endif

// *** hdl/pwmdu_channel.v ***
/*
 one pwm channel: period counter, active-time compare, pending updates.
 assumes requests are single-cycle pulses from logic on the same clock.
*/
`timescale 1ns/1ns
`include "pwmdu_consts.vh"

module pwmdu_channel (
   input wire pclk,
   input wire presetn,
   input wire enable,
   input wire polarity,
   input wire idle_level,
   input wire var_class,
   input wire defer_duty_to_period_end,
   input wire defer_period_to_period_end,
   input wire duty_update_request,
   input wire period_duty_update_request,
   input wire [15:0] req_duty,
   input wire [15:0] req_period,
   output reg pwm_out_ff,
   output reg [15:0] duty_ff,
   output reg [15:0] per_ff,
   output reg [15:0] cnt_ff,
   output wire pending
);

   // active time = period * duty / full scale
   function [15:0] pwmdu_hi_time;
      input [15:0] per;
      input [15:0] duty;
      reg [31:0] prod;
      begin
         prod = per * duty;
         pwmdu_hi_time = prod[30:15];
      end
   endfunction

   reg [15:0] pduty_ff, pper_ff;
   reg pdn_ff, act_ff;
   reg [15:0] nxt_duty, nxt_per, nxt_pduty, nxt_pper, nxt_cnt, hi_n;
   reg [16:0] cnt_inc;
   reg nxt_pdn, nxt_act, nxt_out, wrap;

   assign pending = pdn_ff;

   always @* begin
      nxt_duty = duty_ff;
      nxt_per = per_ff;
      nxt_pduty = pduty_ff;
      nxt_pper = pper_ff;
      nxt_pdn = pdn_ff;
      if (period_duty_update_request) begin
         // fixed classes keep their period; the pair stays together
         if (defer_period_to_period_end) begin
            nxt_pper = var_class ? req_period : per_ff;
            nxt_pduty = req_duty;
            nxt_pdn = 1'b1;
         end else begin
            nxt_per = var_class ? req_period : per_ff;
            nxt_duty = req_duty;
            nxt_pdn = 1'b0;
         end
      end else if (duty_update_request) begin
         if (defer_duty_to_period_end) begin
            nxt_pper = pdn_ff ? pper_ff : per_ff;
            nxt_pduty = req_duty;
            nxt_pdn = 1'b1;
         end else begin
            nxt_duty = req_duty;
            nxt_pdn = 1'b0;
         end
      end
      // a shorter new period that the count already passed wraps now
      cnt_inc = {1'b0, cnt_ff} + 17'h00001;
      wrap = (nxt_per == 16'h0000) || (cnt_inc >= {1'b0, nxt_per});
      nxt_cnt = wrap ? 16'h0000 : cnt_inc[15:0];
      if (wrap && nxt_pdn) begin
         nxt_per = nxt_pper;
         nxt_duty = nxt_pduty;
         nxt_pdn = 1'b0;
      end
      if (!enable) begin
         nxt_cnt = 16'h0000;
      end
      hi_n = pwmdu_hi_time(nxt_per, nxt_duty);
      // active phase only starts at a period start: no extra pulse
      if (nxt_cnt == 16'h0000) begin
         nxt_act = (hi_n != 16'h0000);
      end else begin
         nxt_act = act_ff && (nxt_cnt < hi_n);
      end
      if (!enable) begin
         nxt_out = idle_level;
      end else begin
         nxt_out = nxt_act ? polarity : ~polarity;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_ff <= `PWMDU_DUTY_RST;
         per_ff <= `PWMDU_PERIOD_RST;
         pduty_ff <= `PWMDU_DUTY_RST;
         pper_ff <= `PWMDU_PERIOD_RST;
         pdn_ff <= 1'b0;
         cnt_ff <= 16'h0000;
         act_ff <= 1'b0;
         pwm_out_ff <= 1'b0;
      end else begin
         duty_ff <= nxt_duty;
         per_ff <= nxt_per;
         pduty_ff <= nxt_pduty;
         pper_ff <= nxt_pper;
         pdn_ff <= nxt_pdn;
         cnt_ff <= nxt_cnt;
         act_ff <= nxt_act;
         pwm_out_ff <= nxt_out;
      end
   end

endmodule // pwmdu_channel

// *** hdl/pwmdu_top.v ***
/*
 pwm duty and period update block: apb register slave and four channels.
 assumes an apb master on pclk; channel outputs reach the pins through one shared flop stage.
*/
`timescale 1ns/1ns
`include "pwmdu_consts.vh"

// Summary of operation
// - duty request is 16 bits, limited to 0x0000..0x8000, hits one channel
// - zero duty holds the output at the inverse of the polarity
// - full duty holds the output at the polarity level
// - duty between limits toggles each period, active level from polarity
// - deferred duty mode holds new duty pending until the period boundary
// - a duty change never produces a short spurious pulse
// - combined request applies a new period and duty as one pair
// - deferred period mode loads the new period when the period ends
// - combined change in deferred period mode produces no glitch or cut pulse
// - only variable-period class channels accept a new period
// - zero period ignores duty and drives the zero-duty level
// - each channel holds default period, duty, polarity, idle and class
module pwmdu_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata_ff,
   output reg pready_ff,
   output reg pslverr_ff,
   output reg [3:0] pwm_out_ff
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // duty values above full scale are clamped rather than wrapped
   function [15:0] pwmdu_clamp;
      input [15:0] d;
      begin
         if (d > `PWMDU_DUTY_FULL) begin
            pwmdu_clamp = `PWMDU_DUTY_FULL;
         end else begin
            pwmdu_clamp = d;
         end
      end
   endfunction

   // byte-lane merge for stored registers
   function [31:0] pwmdu_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer b;
      begin
         pwmdu_merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               pwmdu_merge[8*b +: 8] = wd[8*b +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   reg [`PWMDU_CFG_W-1:0] cfg_ff [0:`PWMDU_NCH-1];
   reg [15:0] stage_per_ff [0:`PWMDU_NCH-1];
   reg [3:0] duty_req_ff;
   reg [3:0] pd_req_ff;
   reg [15:0] req_duty_ff;
   reg [15:0] req_per_ff;

   wire [3:0] ch_out;
   wire [3:0] ch_pend;
   wire [63:0] ch_duty;
   wire [63:0] ch_per;
   wire [63:0] ch_cnt;

   wire setup_ph;
   wire access_ph;
   wire wr_go;
   wire in_ch;
   wire is_outs;
   wire [1:0] sel_ch;
   wire [3:0] sel_ofs;
   wire full_half;

   reg [31:0] nxt_rdata;
   reg nxt_err;
   reg nxt_ready;
   reg [31:0] wr_cfg;
   reg [31:0] wr_per;
   integer i;

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_go = access_ph && pready_ff && pwrite && !pslverr_ff;
   assign in_ch = (paddr < `PWMDU_CH_LIMIT) && (paddr[1:0] == 2'h0);
   assign is_outs = (paddr == `PWMDU_OFS_OUTS);
   assign sel_ch = paddr[5:4];
   assign sel_ofs = paddr[3:0];
   // requests carry a 16-bit value and need both low lanes to be coherent
   assign full_half = (pstrb[1:0] == 2'h3);

   // read data, error and ready are all prepared in the setup cycle, so
   // every access completes in its first access cycle with no wait state
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_err = 1'b0;
      nxt_ready = 1'b0;
      if (setup_ph) begin
         nxt_ready = 1'b1;
         if (in_ch) begin
            case (sel_ofs)
               `PWMDU_OFS_CFG: begin
                  nxt_rdata = {25'h0000000, cfg_ff[sel_ch]};
               end
               `PWMDU_OFS_DUTY: begin
                  nxt_rdata = {ch_pend[sel_ch], 15'h0000,
                     ch_duty[16*sel_ch +: 16]};
               end
               `PWMDU_OFS_PERIOD: begin
                  nxt_rdata = {ch_per[16*sel_ch +: 16], stage_per_ff[sel_ch]};
               end
               `PWMDU_OFS_PDREQ: begin
                  nxt_rdata = {ch_cnt[16*sel_ch +: 16], 14'h0000,
                     ch_pend[sel_ch], ch_out[sel_ch]};
                  if (pwrite && !full_half) begin
                     nxt_err = 1'b1;
                  end
               end
               default: begin
                  nxt_err = 1'b1;
               end
            endcase
            if (pwrite && (sel_ofs == `PWMDU_OFS_DUTY) && !full_half) begin
               nxt_err = 1'b1;
            end
         end else if (is_outs) begin
            nxt_rdata = {28'h0000000, pwm_out_ff};
            if (pwrite) begin
               nxt_err = 1'b1;
            end
         end else begin
            nxt_err = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_ready;
         if (setup_ph) begin
            prdata_ff <= nxt_rdata;
            pslverr_ff <= nxt_err;
         end else if (access_ph && pready_ff) begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration and staging registers

   // merged write words, cut to the stored widths in the register process
   always @* begin
      wr_cfg = pwmdu_merge({25'h0000000, cfg_ff[sel_ch]}, pwdata, pstrb);
      wr_per = pwmdu_merge({16'h0000, stage_per_ff[sel_ch]}, pwdata, pstrb);
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < `PWMDU_NCH; i = i + 1) begin
            cfg_ff[i] <= `PWMDU_CFG_RST;
            stage_per_ff[i] <= `PWMDU_PERIOD_RST;
         end
      end else if (wr_go && in_ch) begin
         if (sel_ofs == `PWMDU_OFS_CFG) begin
            cfg_ff[sel_ch] <= wr_cfg[`PWMDU_CFG_W-1:0];
         end
         if (sel_ofs == `PWMDU_OFS_PERIOD) begin
            stage_per_ff[sel_ch] <= wr_per[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request pulses: one cycle, one channel only

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_req_ff <= 4'h0;
         pd_req_ff <= 4'h0;
         req_duty_ff <= `PWMDU_DUTY_RST;
         req_per_ff <= `PWMDU_PERIOD_RST;
      end else begin
         duty_req_ff <= 4'h0;
         pd_req_ff <= 4'h0;
         if (wr_go && in_ch && (sel_ofs == `PWMDU_OFS_DUTY)) begin
            duty_req_ff[sel_ch] <= 1'b1;
            req_duty_ff <= pwmdu_clamp(pwdata[15:0]);
         end
         if (wr_go && in_ch && (sel_ofs == `PWMDU_OFS_PDREQ)) begin
            // period and duty travel in the same pulse to stay a pair
            pd_req_ff[sel_ch] <= 1'b1;
            req_duty_ff <= pwmdu_clamp(pwdata[15:0]);
            req_per_ff <= stage_per_ff[sel_ch];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels

   genvar g;
   generate
      for (g = 0; g < `PWMDU_NCH; g = g + 1) begin : gen_ch
         pwmdu_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .enable(cfg_ff[g][`PWMDU_CFG_EN]),
            .polarity(cfg_ff[g][`PWMDU_CFG_POL]),
            .idle_level(cfg_ff[g][`PWMDU_CFG_IDLE]),
            .var_class(cfg_ff[g][`PWMDU_CFG_CLS_HI:`PWMDU_CFG_CLS_LO] ==
               `PWMDU_CLS_VAR),
            .defer_duty_to_period_end(cfg_ff[g][`PWMDU_CFG_DEFD]),
            .defer_period_to_period_end(cfg_ff[g][`PWMDU_CFG_DEFP]),
            .duty_update_request(duty_req_ff[g]),
            .period_duty_update_request(pd_req_ff[g]),
            .req_duty(req_duty_ff),
            .req_period(req_per_ff),
            .pwm_out_ff(ch_out[g]),
            .duty_ff(ch_duty[16*g +: 16]),
            .per_ff(ch_per[16*g +: 16]),
            .cnt_ff(ch_cnt[16*g +: 16]),
            .pending(ch_pend[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // pin outputs

   // one extra stage keeps pins on top-level flops; all channels share it,
   // so relative edge timing between channels is preserved
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out_ff <= 4'h0;
      end else begin
         pwm_out_ff <= ch_out;
      end
   end

endmodule // pwmdu_top

// *** verif/pwmdu_top_sva.sv ***
/*
 checker for pwmdu_top: apb answer timing, refusals, read fields, reset.
 assumes it is bound to pwmdu_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module pwmdu_top_sva (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata_ff,
   input wire pready_ff,
   input wire pslverr_ff,
   input wire [3:0] pwm_out_ff
);
   ////////////////////////////////////////////////////////////
   wire acc = psel && penable && pready_ff;
   wire ok_a = paddr[1:0] == 2'b00 && paddr < 8'h40;
   // duty and pdreq both sit at offsets with bit 2 set
   wire bad_strb = pwrite && paddr[2] && pstrb[1:0] != 2'b11;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   AST_PREADY_SETUP: assert property (
      psel && !penable |=> pready_ff) else $error("no answer to setup");
   AST_PREADY_CAUSE: assert property (
      pready_ff |-> $past(psel && !penable)) else $error("stray pready");
   AST_PREADY_PULSE: assert property (
      pready_ff |=> !pready_ff) else $error("pready held");
   AST_ERR_UNALIGNED: assert property (
      acc && paddr[1:0] != 2'b00 |-> pslverr_ff) else $error("unaligned ok");
   AST_ERR_OUTS_WR: assert property (
      acc && pwrite && paddr == 8'h40 |-> pslverr_ff) else $error("outs wr");
   AST_ERR_STRB: assert property (
      acc && ok_a && bad_strb |-> pslverr_ff) else $error("strobe taken");
   AST_NO_ERR: assert property (
      acc && ok_a && !bad_strb |-> !pslverr_ff) else $error("good refused");
   AST_DUTY_MAX: assert property (
      acc && !pwrite && ok_a && paddr[3:0] == 4'h4
      |-> prdata_ff[15:0] <= 16'h8000) else $error("duty above full");
   AST_CFG_RSVD: assert property (
      acc && !pwrite && ok_a && paddr[3:0] == 4'h0
      |-> prdata_ff[31:7] == 25'h0) else $error("cfg reserved set");
   AST_RESET_QUIET: assert property (
      $rose(presetn) |-> pwm_out_ff == 4'h0 && !pready_ff)
      else $error("outputs active at reset release");
   cover property (acc && pwrite && paddr[3:0] == 4'hC);
   cover property (acc && pslverr_ff);
   cover property ($fell(pwm_out_ff[0]));
endmodule // pwmdu_top_sva

bind pwmdu_top pwmdu_top_sva u_pwmdu_top_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff),
   .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
   .pwm_out_ff(pwm_out_ff));

// *** verif/pwmdu_top_test.sv ***
/*
 bench for pwmdu_top: apb tasks, one task per scenario, verdict.
 assumes the design header is on the include path of the design files.
*/
`timescale 1ns/1ns
module pwmdu_top_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   wire [31:0] prdata_ff;
   wire pready_ff;
   wire pslverr_ff;
   wire [3:0] pwm_out_ff;
   int n_errors = 0;
   int checked = 0;
   logic [31:0] r;
   logic e;
   always #4 pclk = ~pclk;
   pwmdu_top u_pwmdu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .pwm_out_ff(pwm_out_ff));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input [31:0] ex, input [31:0] got);
      checked++;
      if (got !== ex) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, ex, got);
      end
   endtask
   // wait has no bound of its own: the watchdog ends a hang
   task automatic apb(input w, input [7:0] a, input [31:0] d,
                      input [3:0] s);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_ff !== 1'b1);
      r = prdata_ff;
      e = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input [7:0] a);
      apb(1'b0, a, 32'h0, 4'hF);
   endtask
   // high cycles over a window of n cycles equal the expected count ex
   task automatic hi(input int ch, input int n, input [31:0] ex);
      int h;
      h = 0;
      repeat (n) begin
         @(posedge pclk);
         if (pwm_out_ff[ch] === 1'b1) h++;
      end
      chk("high_cycles", ex, h);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(8'h00); chk("cfg0", 32'h49, r);
      rd(8'h04); chk("duty0", 16'h4000, r[15:0]);
      rd(8'h08); chk("per0", 16'h03E8, r[31:16]);
   endtask
   // runs early so the reset period of 1000 is far from its end
   task automatic t_defer;
      wr(8'h20, 32'h59);
      wr(8'h24, 32'h2000);
      rd(8'h24); chk("duty2_pend", 32'h80004000, r);
      wr(8'h30, 32'h69);
      wr(8'h38, 32'h1E);
      wr(8'h3C, 32'h4000);
      rd(8'h38); chk("per3_old", 16'h03E8, r[31:16]);
      repeat (1000) @(posedge pclk);
      rd(8'h24); chk("duty2_new", 32'h2000, r);
      rd(8'h38); chk("per3_new", 16'h001E, r[31:16]);
      repeat (40) @(posedge pclk);
      hi(3, 30, 15);
   endtask
   task automatic t_mod;
      wr(8'h08, 32'h14);
      wr(8'h0C, 32'h4000);
      rd(8'h08); chk("per0", 16'h0014, r[31:16]);
      repeat (25) @(posedge pclk);
      hi(0, 20, 10);
      wr(8'h04, 32'h6000);
      repeat (25) @(posedge pclk);
      hi(0, 20, 15);
   endtask
   task automatic t_limits;
      wr(8'h04, 32'h0);
      repeat (25) @(posedge pclk);
      hi(0, 40, 0);
      wr(8'h04, 32'hFFFF);
      rd(8'h04); chk("clamp", 16'h8000, r[15:0]);
      repeat (25) @(posedge pclk);
      hi(0, 40, 40);
      rd(8'h14); chk("duty1", 16'h4000, r[15:0]);
      apb(1'b1, 8'h04, 32'h0, 4'h1); chk("strb_err", 1'b1, e);
      wr(8'h05, 32'h0); chk("align_err", 1'b1, e);
      wr(8'h40, 32'h0); chk("outs_err", 1'b1, e);
      rd(8'h04); chk("duty_kept", 16'h8000, r[15:0]);
   endtask
   task automatic t_pol;
      wr(8'h00, 32'h48);
      repeat (25) @(posedge pclk);
      hi(0, 40, 0);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h8000);
      repeat (25) @(posedge pclk);
      hi(0, 40, 40);
      rd(8'h40); chk("outs0", 1'b1, r[0]);
      wr(8'h00, 32'h49);
      repeat (25) @(posedge pclk);
      hi(0, 40, 0);
      // disabled channel with idle level high
      wr(8'h00, 32'h0A);
      repeat (25) @(posedge pclk);
      hi(0, 40, 40);
   endtask
   task automatic t_fixed;
      wr(8'h10, 32'h41);
      wr(8'h18, 32'h14);
      wr(8'h1C, 32'h2000);
      rd(8'h18); chk("per1_kept", 16'h03E8, r[31:16]);
      rd(8'h14); chk("duty1_new", 16'h2000, r[15:0]);
      wr(8'h10, 32'h45);
      wr(8'h1C, 32'h1000);
      rd(8'h18); chk("per1_shift", 16'h03E8, r[31:16]);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      stop_test;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_defer;
      t_mod;
      t_limits;
      t_pol;
      t_fixed;
      stop_test;
   end
endmodule // pwmdu_top_test
